// ===== core/sec_engine_regs.sv
// control, debug and statistics register bank of the spatial engine
`timescale 1ns/10ps
// Operation
// - both skip bits set route audio around both filters, coefficients kept.
// - each stage runs only while enabled; disabling keeps registers and memory.
// - array taps from 8-bit field, prefilter taps 7-bit; prefilter not longer (not enforced: o_pre_taps can exceed o_array_taps).
// - two-bit route field per output picks array channel 0 or 1.
// - first compressor set: 5-bit threshold, pre-gain 2..256, ratio 1:1..16:1.
// - 3-bit post gain codes mean 1 to 8 linear.
// - second compressor register holds two full parameter sets.
// - 8-bit field selects parameter set per array compressor.
// - one injected 24-bit debug sample drives both left and right.
// - one bit enables debug mode, another enables single stepping.
// - 4-bit index and filter pick choose accumulator for readback.
// - statistics control has channel select for prefilter and array counters.
// - mode 0000 counts every sample on the selected channel.
// - mode 0001 counts overflow events on the selected channel.
// - mode 0010 counts frequency error events.
// - modes 1000..1111 count magnitude hits on widening top slice.
// - four counters, two per filter, each with own mode field.
// - clear bit holds a filter's counter pair at zero; counters readable.
// - selected accumulator readable as low word and upper word, 48 bits.
// - compressor output 24-bit and debug data word are readable.
// - coefficient writes accepted only while debug mode is on.
module sec_engine_regs
	import sec_pkg::*;
(
	input  wire logic                  i_clk,
	input  wire logic                  i_rstn,
	input  wire sec_pkg::sec_req_t     i_req,
	output logic [31:0]                o_rdata,
	output logic                       o_rvalid,
	output logic                       o_coef_we,
	output logic [10:0]                o_coef_addr,
	output logic [31:0]                o_coef_wdata,
	input  wire logic [23:0]           i_in_left,
	input  wire logic [23:0]           i_in_right,
	output logic [23:0]                o_eng_left,
	output logic [23:0]                o_eng_right,
	input  wire logic [23:0]           i_arr_ch0,
	input  wire logic [23:0]           i_arr_ch1,
	output logic [23:0]                o_out1,
	output logic [23:0]                o_out2,
	output logic                       o_pre_run,
	output logic                       o_array_run,
	output logic                       o_full_bypass,
	output logic [7:0]                 o_array_taps,
	output logic [6:0]                 o_pre_taps,
	output sec_pkg::sec_comp_t [2:0]   o_comp_set,
	output logic [7:0]                 o_array_comp_select,
	output logic                       o_debug_mode_on,
	output logic                       o_step_on,
	output logic [3:0]                 o_accumulator_index,
	output logic                       o_acc_filter_pick,
	input  wire logic [47:0]           i_acc_value,
	input  wire logic [23:0]           i_comp_out,
	input  wire logic [31:0]           i_debug_word,
	input  wire sec_pkg::sec_evt_t     i_pre_evt,
	input  wire sec_pkg::sec_evt_t     i_arr_evt
);
	import sec_pkg::*;

	logic [31:0] ctrl;
	logic [31:0] comp1;
	logic [31:0] comp2;
	logic [31:0] dinj;
	logic [31:0] dctl;
	logic [31:0] stat;
	logic [31:0] pcnt1;
	logic [31:0] pcnt2;
	logic [31:0] acnt1;
	logic [31:0] acnt2;
	logic [1:0]  out1_route;
	logic [1:0]  out2_route;
	logic [23:0] injected_audio_word;
	logic        prefilter_counters_clear;
	logic        array_counters_clear;
	logic        wr_cfg;

	function automatic logic [23:0] route_pick(input logic [1:0] sel,
		input logic [23:0] ch0, input logic [23:0] ch1);
		// codes 2 and 3 have no channel behind them and give silence
		case (sel)
			2'h0:    route_pick = ch0;
			2'h1:    route_pick = ch1;
			default: route_pick = 24'h0;
		endcase
	endfunction

	// register writes; read-only addresses and coefficient space fall through
	assign wr_cfg = i_req.wr;
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ctrl  <= SEC_RST_CTRL;
			comp1 <= SEC_RST_COMP1;
			comp2 <= SEC_RST_COMP2;
			dinj  <= SEC_RST_DINJ;
			dctl  <= SEC_RST_DCTL;
			stat  <= SEC_RST_STAT;
		end else if (wr_cfg) begin
			case (i_req.addr)
				SEC_ADR_CTRL:  ctrl  <= i_req.wdata & SEC_MSK_CTRL;
				SEC_ADR_COMP1: comp1 <= i_req.wdata & SEC_MSK_COMP1;
				SEC_ADR_COMP2: comp2 <= i_req.wdata & SEC_MSK_COMP2;
				SEC_ADR_DINJ:  dinj  <= i_req.wdata & SEC_MSK_DINJ;
				SEC_ADR_DCTL:  dctl  <= i_req.wdata & SEC_MSK_DCTL;
				SEC_ADR_STAT:  stat  <= i_req.wdata & SEC_MSK_STAT;
				default: ;
			endcase
		end
	end

	// configuration fields seen by the engine
	assign o_array_taps = ctrl[SEC_CTRL_ATAP +: 8];
	assign o_pre_taps   = ctrl[SEC_CTRL_PTAP +: 7];
	assign out1_route   = ctrl[SEC_CTRL_R1 +: 2];
	assign out2_route   = ctrl[SEC_CTRL_R2 +: 2];
	// disabling only stops the stage; nothing here clears state
	assign o_pre_run    = ctrl[SEC_CTRL_PEN];
	assign o_array_run  = ctrl[SEC_CTRL_AEN];
	assign o_full_bypass = ctrl[SEC_CTRL_PSK] & ctrl[SEC_CTRL_ASK];

	// three compressor parameter sets, decoded
	assign o_comp_set[0] = sec_comp_decode(comp1[15:0]);
	assign o_comp_set[1] = sec_comp_decode(comp2[15:0]);
	assign o_comp_set[2] = sec_comp_decode(comp2[31:SEC_COMP_HI]);
	assign o_array_comp_select = comp1[SEC_COMP_SEL +: 8];

	// debug controls
	assign injected_audio_word = dinj[23:0];
	assign o_debug_mode_on     = dctl[SEC_DCTL_DBG];
	assign o_step_on           = dctl[SEC_DCTL_STEP];
	assign o_accumulator_index = dctl[SEC_DCTL_IDX +: 4];
	assign o_acc_filter_pick   = dctl[SEC_DCTL_PICK];

	// engine input: the injected word replaces both channels in debug mode
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_eng_left  <= 24'h0;
			o_eng_right <= 24'h0;
		end else if (o_debug_mode_on) begin
			o_eng_left  <= injected_audio_word;
			o_eng_right <= injected_audio_word;
		end else begin
			o_eng_left  <= i_in_left;
			o_eng_right <= i_in_right;
		end
	end

	// output routing; the bypass passes the raw input straight through
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_out1 <= 24'h0;
			o_out2 <= 24'h0;
		end else if (o_full_bypass) begin
			o_out1 <= i_in_left;
			o_out2 <= i_in_right;
		end else begin
			o_out1 <= route_pick(out1_route, i_arr_ch0, i_arr_ch1);
			o_out2 <= route_pick(out2_route, i_arr_ch0, i_arr_ch1);
		end
	end

	// coefficient writes are dropped outside debug mode, with no error shown
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_coef_we    <= 1'b0;
			o_coef_addr  <= 11'h0;
			o_coef_wdata <= 32'h0;
		end else begin
			o_coef_we <= wr_cfg & (i_req.addr < SEC_COEF_TOP) & o_debug_mode_on;
			if (wr_cfg) begin
				o_coef_addr  <= i_req.addr[10:0];
				o_coef_wdata <= i_req.wdata;
			end
		end
	end

	// statistics counters, one pair per filter
	assign prefilter_counters_clear = stat[SEC_STAT_PCLR];
	assign array_counters_clear     = stat[SEC_STAT_ACLR];

	sec_stat_counter u_pcnt1 (
		.i_clk      (i_clk),
		.i_rstn     (i_rstn),
		.i_clear    (prefilter_counters_clear),
		.i_mode     (stat[SEC_STAT_PM1 +: 4]),
		.i_chan_sel (stat[SEC_STAT_PCH +: 4]),
		.i_evt      (i_pre_evt),
		.o_count    (pcnt1)
	);
	sec_stat_counter u_pcnt2 (
		.i_clk      (i_clk),
		.i_rstn     (i_rstn),
		.i_clear    (prefilter_counters_clear),
		.i_mode     (stat[SEC_STAT_PM2 +: 4]),
		.i_chan_sel (stat[SEC_STAT_PCH +: 4]),
		.i_evt      (i_pre_evt),
		.o_count    (pcnt2)
	);
	sec_stat_counter u_acnt1 (
		.i_clk      (i_clk),
		.i_rstn     (i_rstn),
		.i_clear    (array_counters_clear),
		.i_mode     (stat[SEC_STAT_AM1 +: 4]),
		.i_chan_sel (stat[SEC_STAT_ACH +: 4]),
		.i_evt      (i_arr_evt),
		.o_count    (acnt1)
	);
	sec_stat_counter u_acnt2 (
		.i_clk      (i_clk),
		.i_rstn     (i_rstn),
		.i_clear    (array_counters_clear),
		.i_mode     (stat[SEC_STAT_AM2 +: 4]),
		.i_chan_sel (stat[SEC_STAT_ACH +: 4]),
		.i_evt      (i_arr_evt),
		.o_count    (acnt2)
	);

	// registered read port; unmapped addresses answer zero
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rdata  <= 32'h0;
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= i_req.rd;
			if (i_req.rd) begin
				case (i_req.addr)
					SEC_ADR_CTRL:  o_rdata <= ctrl;
					SEC_ADR_COMP1: o_rdata <= comp1;
					SEC_ADR_COMP2: o_rdata <= comp2;
					SEC_ADR_DINJ:  o_rdata <= dinj;
					SEC_ADR_DCTL:  o_rdata <= dctl;
					SEC_ADR_STAT:  o_rdata <= stat;
					SEC_ADR_DRB:   o_rdata <= i_debug_word;
					SEC_ADR_ACCL:  o_rdata <= i_acc_value[31:0];
					SEC_ADR_ACCH:  o_rdata <= {16'h0, i_acc_value[47:32]};
					SEC_ADR_COUT:  o_rdata <= {8'h0, i_comp_out};
					SEC_ADR_PC1:   o_rdata <= pcnt1;
					SEC_ADR_PC2:   o_rdata <= pcnt2;
					SEC_ADR_AC1:   o_rdata <= acnt1;
					SEC_ADR_AC2:   o_rdata <= acnt2;
					default:       o_rdata <= 32'h0;
				endcase
			end
		end
	end

	// checks
	sequence s_prefilter_counters_clear_two;
		prefilter_counters_clear [*2];
	endsequence

	sequence s_dbg_coef_wr;
		o_debug_mode_on && i_req.wr && (i_req.addr < SEC_COEF_TOP);
	endsequence

	sequence s_array_counters_clear_two;
		array_counters_clear [*2];
	endsequence

	a_bypass_passes: assert property (@(posedge i_clk) disable iff (!i_rstn)
		o_full_bypass |=> (o_out1 == $past(i_in_left)) && (o_out2 == $past(i_in_right)))
		else $error("bypass did not pass input through");

	a_stage_stop: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(i_req.wr && i_req.addr == SEC_ADR_CTRL && !i_req.wdata[SEC_CTRL_PEN])
		|=> !o_pre_run && $stable(comp1) && $stable(dctl))
		else $error("prefilter still runs or state lost");

	a_route_pick: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(!o_full_bypass && out1_route == 2'h1) |=> o_out1 == $past(i_arr_ch1))
		else $error("output one not routed from channel one");

	a_inject_both: assert property (@(posedge i_clk) disable iff (!i_rstn)
		o_debug_mode_on |=> (o_eng_left == o_eng_right)
		&& (o_eng_left == $past(injected_audio_word)))
		else $error("injected word not on both channels");

	a_coef_gate: assert property (@(posedge i_clk) disable iff (!i_rstn)
		s_dbg_coef_wr |=> o_coef_we ##1 !o_coef_we || $past(i_req.wr))
		else $error("coefficient write not taken in debug mode");

	a_coef_block: assert property (@(posedge i_clk) disable iff (!i_rstn)
		!o_debug_mode_on |=> !o_coef_we)
		else $error("coefficient write outside debug mode");

	a_unused_zero: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(i_req.rd && i_req.addr == SEC_ADR_DCTL) |=> o_rvalid && o_rdata[31:8] == 24'h0)
		else $error("unused debug control bits read nonzero");

	a_clear_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
		s_prefilter_counters_clear_two |-> pcnt1 == 32'h0 && pcnt2 == 32'h0)
		else $error("prefilter counters not held clear");

	a_sample_count: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(!array_counters_clear && stat[SEC_STAT_AM1 +: 4] == 4'h0 && i_arr_evt.sample
		&& stat[SEC_STAT_ACH +: 4] == {1'b0, i_arr_evt.chan})
		|=> acnt1 == $past(acnt1) + 32'h1)
		else $error("sample count did not step by one");

	a_read_answer: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(i_req.rd && i_req.addr == SEC_ADR_ACCH)
		|=> o_rvalid && o_rdata == {16'h0, $past(i_acc_value[47:32])})
		else $error("upper accumulator word wrong");

	a_array_stop: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(i_req.wr && i_req.addr == SEC_ADR_CTRL && !i_req.wdata[SEC_CTRL_AEN])
		|=> !o_array_run && $stable(comp2) && $stable(stat))
		else $error("array filter still runs or state lost");

	a_route_two: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(!o_full_bypass && out2_route == 2'h0)
		|=> o_out2 == $past(i_arr_ch0))
		else $error("output two not routed from channel zero");

	a_route_quiet: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(!o_full_bypass && out1_route[1])
		|=> o_out1 == 24'h0)
		else $error("unassigned route code not silent");

	a_engine_pass: assert property (@(posedge i_clk) disable iff (!i_rstn)
		!o_debug_mode_on
		|=> (o_eng_left == $past(i_in_left)) && (o_eng_right == $past(i_in_right)))
		else $error("engine input not passed outside debug");

	a_clear_array: assert property (@(posedge i_clk) disable iff (!i_rstn)
		s_array_counters_clear_two
		|-> acnt1 == 32'h0 && acnt2 == 32'h0)
		else $error("array counters not held clear");

	a_read_low: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(i_req.rd && i_req.addr == SEC_ADR_ACCL)
		|=> o_rvalid && o_rdata == $past(i_acc_value[31:0]))
		else $error("lower accumulator word wrong");

	a_comp_read: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(i_req.rd && i_req.addr == SEC_ADR_COUT)
		|=> o_rvalid && o_rdata == {8'h0, $past(i_comp_out)})
		else $error("compressor output word wrong");

	a_ctrl_unused: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(i_req.wr && i_req.addr == SEC_ADR_CTRL)
		|=> (ctrl & ~SEC_MSK_CTRL) == 32'h0)
		else $error("unused control bits stored");

	a_ferr_count: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(!prefilter_counters_clear && stat[SEC_STAT_PM1 +: 4] == 4'h2 && i_pre_evt.ferr)
		|=> pcnt1 == $past(pcnt1) + 32'h1)
		else $error("frequency error not counted");
endmodule // sec_engine_regs

// ===== core/sec_pkg.sv
// package: register map, field layout and carrier types of the spatial engine register bank
package sec_pkg;
	// register addresses as word indices of the configuration space
	localparam logic [11:0] SEC_ADR_CTRL  = 12'h500;
	localparam logic [11:0] SEC_ADR_COMP1 = 12'h501;
	localparam logic [11:0] SEC_ADR_COMP2 = 12'h502;
	localparam logic [11:0] SEC_ADR_DINJ  = 12'h503;
	localparam logic [11:0] SEC_ADR_DCTL  = 12'h504;
	localparam logic [11:0] SEC_ADR_STAT  = 12'h505;
	localparam logic [11:0] SEC_ADR_DRB   = 12'h506;
	localparam logic [11:0] SEC_ADR_ACCL  = 12'h509;
	localparam logic [11:0] SEC_ADR_ACCH  = 12'h50a;
	localparam logic [11:0] SEC_ADR_COUT  = 12'h50b;
	localparam logic [11:0] SEC_ADR_PC1   = 12'h50c;
	localparam logic [11:0] SEC_ADR_PC2   = 12'h50d;
	localparam logic [11:0] SEC_ADR_AC1   = 12'h50e;
	localparam logic [11:0] SEC_ADR_AC2   = 12'h50f;
	// first index above the coefficient space
	localparam logic [11:0] SEC_COEF_TOP  = 12'h500;

	// reset values
	localparam logic [31:0] SEC_RST_CTRL  = 32'hc1e47fff;
	localparam logic [31:0] SEC_RST_COMP1 = 32'h00001198;
	localparam logic [31:0] SEC_RST_COMP2 = 32'h11b811b8;
	localparam logic [31:0] SEC_RST_DINJ  = 32'h00000000;
	localparam logic [31:0] SEC_RST_DCTL  = 32'h00000000;
	localparam logic [31:0] SEC_RST_STAT  = 32'h80008000;

	// writable bits; the rest store nothing and read zero after a write
	localparam logic [31:0] SEC_MSK_CTRL  = 32'hf00f7fff;
	localparam logic [31:0] SEC_MSK_COMP1 = 32'h00ff77ff;
	localparam logic [31:0] SEC_MSK_COMP2 = 32'h77ff77ff;
	localparam logic [31:0] SEC_MSK_DINJ  = 32'h00ffffff;
	localparam logic [31:0] SEC_MSK_DCTL  = 32'h000000df;
	localparam logic [31:0] SEC_MSK_STAT  = 32'h8fff8fff;

	// field positions
	localparam int SEC_CTRL_ATAP = 0;
	localparam int SEC_CTRL_PTAP = 8;
	localparam int SEC_CTRL_R1   = 16;
	localparam int SEC_CTRL_R2   = 18;
	localparam int SEC_CTRL_PSK  = 28;
	localparam int SEC_CTRL_ASK  = 29;
	localparam int SEC_CTRL_PEN  = 30;
	localparam int SEC_CTRL_AEN  = 31;
	localparam int SEC_COMP_HI   = 16;
	localparam int SEC_COMP_SEL  = 16;
	localparam int SEC_CMP_THR   = 0;
	localparam int SEC_CMP_PRE   = 5;
	localparam int SEC_CMP_RAT   = 8;
	localparam int SEC_CMP_POST  = 12;
	localparam int SEC_DCTL_IDX  = 0;
	localparam int SEC_DCTL_PICK = 4;
	localparam int SEC_DCTL_STEP = 6;
	localparam int SEC_DCTL_DBG  = 7;
	localparam int SEC_STAT_PCH  = 0;
	localparam int SEC_STAT_PM1  = 4;
	localparam int SEC_STAT_PM2  = 8;
	localparam int SEC_STAT_PCLR = 15;
	localparam int SEC_STAT_ACH  = 16;
	localparam int SEC_STAT_AM1  = 20;
	localparam int SEC_STAT_AM2  = 24;
	localparam int SEC_STAT_ACLR = 31;

	// ratio in thirds, post gain in quarters, per code
	localparam logic [5:0] SEC_RATIO_X3 [8] = '{6'h03, 6'h06, 6'h08, 6'h0c,
		6'h10, 6'h18, 6'h20, 6'h30};
	localparam logic [5:0] SEC_POST_X4 [8] = '{6'h04, 6'h05, 6'h06, 6'h08,
		6'h0a, 6'h0c, 6'h10, 6'h20};

	// counter event sources
	typedef enum logic [2:0] {SEC_SRC_SAMPLE, SEC_SRC_OVF, SEC_SRC_FERR,
		SEC_SRC_MAG, SEC_SRC_IDLE} sec_src_t;

	// configuration access from the serial configuration interface
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [11:0] addr;
		logic [31:0] wdata;
	} sec_req_t;

	// per-filter engine events
	typedef struct packed {
		logic       sample;
		logic [2:0] chan;
		logic       ovf;
		logic       ferr;
		logic [7:0] mag;
	} sec_evt_t;

	// one decoded compressor parameter set
	typedef struct packed {
		logic [4:0] thr;
		logic [3:0] pre_shift;
		logic [5:0] ratio_x3;
		logic [5:0] post_x4;
	} sec_comp_t;

	function automatic sec_comp_t sec_comp_decode(input logic [15:0] h);
		sec_comp_t c;
		c.thr       = h[SEC_CMP_THR +: 5];
		c.pre_shift = {1'b0, h[SEC_CMP_PRE +: 3]} + 4'h1;
		c.ratio_x3  = SEC_RATIO_X3[h[SEC_CMP_RAT +: 3]];
		c.post_x4   = SEC_POST_X4[h[SEC_CMP_POST +: 3]];
		return c;
	endfunction
endpackage

// ===== core/sec_stat_counter.sv
// statistics counter with selectable event source
`timescale 1ns/10ps
module sec_stat_counter
	import sec_pkg::*;
(
	input  wire logic           i_clk,
	input  wire logic           i_rstn,
	input  wire logic           i_clear,
	input  wire logic [3:0]     i_mode,
	input  wire logic [3:0]     i_chan_sel,
	input  wire sec_pkg::sec_evt_t i_evt,
	output logic [31:0]         o_count
);
	import sec_pkg::*;

	sec_src_t   src;
	logic [7:0] slice_mask;
	logic       chan_ok;
	logic       next_hit;

	// mode decode; codes 0011..0111 count nothing
	always_comb begin
		if (i_mode[3])
			src = SEC_SRC_MAG;
		else if (i_mode == 4'h0)
			src = SEC_SRC_SAMPLE;
		else if (i_mode == 4'h1)
			src = SEC_SRC_OVF;
		else if (i_mode == 4'h2)
			src = SEC_SRC_FERR;
		else
			src = SEC_SRC_IDLE;
	end

	// slice widens from bit 7 alone to bits 7..0
	assign slice_mask = 8'hff << (3'h7 - i_mode[2:0]);
	assign chan_ok = (i_chan_sel == {1'b0, i_evt.chan});

	always_comb begin
		next_hit = 1'b0;
		case (src)
			SEC_SRC_SAMPLE: next_hit = i_evt.sample & chan_ok;
			SEC_SRC_OVF:    next_hit = i_evt.ovf & chan_ok;
			SEC_SRC_FERR:   next_hit = i_evt.ferr;
			SEC_SRC_MAG:    next_hit = i_evt.sample & chan_ok & (|(i_evt.mag & slice_mask));
			default:        next_hit = 1'b0;
		endcase
	end

	// held at zero while clear is set, so no count escapes the clear
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			o_count <= 32'h0;
		else if (i_clear)
			o_count <= 32'h0;
		else if (next_hit)
			o_count <= o_count + 32'h1;
	end
endmodule // sec_stat_counter

// ===== test/testbench.sv
// self-checking bench for the spatial engine register bank
`timescale 1ns/10ps
module testbench;
	import sec_pkg::*;
	logic              i_clk = 1'b0;
	logic              i_rstn = 1'b0;
	sec_req_t          i_req = '0;
	logic [23:0]       i_in_left = '0, i_in_right = '0;
	logic [23:0]       i_arr_ch0 = '0, i_arr_ch1 = '0, i_comp_out = '0;
	logic [47:0]       i_acc_value = '0;
	logic [31:0]       i_debug_word = '0;
	sec_evt_t          i_pre_evt = '0, i_arr_evt = '0;
	logic [31:0]       o_rdata, o_coef_wdata;
	logic              o_rvalid, o_coef_we, o_pre_run, o_array_run, o_full_bypass;
	logic [10:0]       o_coef_addr;
	logic [23:0]       o_eng_left, o_eng_right, o_out1, o_out2;
	logic [7:0]        o_array_taps, o_array_comp_select;
	logic [6:0]        o_pre_taps;
	sec_comp_t [2:0]   o_comp_set;
	logic              o_debug_mode_on, o_step_on, o_acc_filter_pick;
	logic [3:0]        o_accumulator_index;
	int                miscompares = 0;
	int                n_checks = 0;

	// dut with every port reachable from the bench
	sec_engine_regs u_sec_engine_regs (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(i_req),
		.o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_coef_we(o_coef_we),
		.o_coef_addr(o_coef_addr), .o_coef_wdata(o_coef_wdata), .i_in_left(i_in_left),
		.i_in_right(i_in_right), .o_eng_left(o_eng_left), .o_eng_right(o_eng_right),
		.i_arr_ch0(i_arr_ch0), .i_arr_ch1(i_arr_ch1), .o_out1(o_out1), .o_out2(o_out2),
		.o_pre_run(o_pre_run), .o_array_run(o_array_run), .o_full_bypass(o_full_bypass),
		.o_array_taps(o_array_taps), .o_pre_taps(o_pre_taps), .o_comp_set(o_comp_set),
		.o_array_comp_select(o_array_comp_select), .o_debug_mode_on(o_debug_mode_on),
		.o_step_on(o_step_on), .o_accumulator_index(o_accumulator_index),
		.o_acc_filter_pick(o_acc_filter_pick), .i_acc_value(i_acc_value),
		.i_comp_out(i_comp_out), .i_debug_word(i_debug_word), .i_pre_evt(i_pre_evt),
		.i_arr_evt(i_arr_evt));

	// 25 mhz clock
	always #20 i_clk = ~i_clk;

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// bus tasks are entered just after a falling edge
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(negedge i_clk);
		i_req.wr = 1'b1;
		i_req.addr = a;
		i_req.wdata = d;
		@(negedge i_clk);
		i_req.wr = 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(negedge i_clk);
		i_req.rd = 1'b1;
		i_req.addr = a;
		@(negedge i_clk);
		i_req.rd = 1'b0;
		d = o_rdata;
	endtask

	// the answer must stand exactly one cycle after the request
	task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		chk({o_rvalid, d}, {1'b1, exp});
	endtask

	// reference event decode for one counter
	function automatic int hit(input logic [3:0] m, input logic [3:0] s, input sec_evt_t e);
		logic mt;
		mt = ({1'b0, e.chan} == s);
		case (m)
			4'h0: return int'(e.sample & mt);
			4'h1: return int'(e.ovf & mt);
			4'h2: return int'(e.ferr);
			default: return int'(m[3] & e.sample & mt & (|(e.mag & ~(8'hff >> (m[2:0] + 1)))));
		endcase
	endfunction

	function automatic logic [23:0] route(input logic [1:0] c);
		return (c == 2'h0) ? i_arr_ch0 : (c == 2'h1) ? i_arr_ch1 : 24'h0;
	endfunction

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// watchdog sized well above the expected run length
	initial begin
		#(40 * 20000);
		miscompares++;
		end_of_test();
	end

	logic [11:0] ra [6] = '{SEC_ADR_CTRL, SEC_ADR_COMP1, SEC_ADR_COMP2, SEC_ADR_DINJ,
		SEC_ADR_DCTL, SEC_ADR_STAT};
	logic [31:0] rm [6] = '{SEC_MSK_CTRL, SEC_MSK_COMP1, SEC_MSK_COMP2, SEC_MSK_DINJ,
		SEC_MSK_DCTL, SEC_MSK_STAT};
	logic [31:0] rr [6] = '{SEC_RST_CTRL, SEC_RST_COMP1, SEC_RST_COMP2, SEC_RST_DINJ,
		SEC_RST_DCTL, SEC_RST_STAT};
	logic [3:0]  md [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd,
		4'he, 4'hf};
	int          rx3 [8] = '{3, 6, 8, 12, 16, 24, 32, 48};
	int          px4 [8] = '{4, 5, 6, 8, 10, 12, 16, 32};

	// main sequence
	initial begin
		logic [31:0] d, inj;
		logic [47:0] acc;
		logic [3:0]  ps, as;
		logic [2:0]  c;
		sec_evt_t    pe, ae;
		int          cnt [4];
		void'($urandom(78147));
		repeat (16) @(negedge i_clk);
		i_rstn = 1'b1;
		@(negedge i_clk);
		for (int i = 0; i < 6; i++) rchk(ra[i], rr[i]);
		chk({o_pre_run, o_array_run, o_full_bypass, o_array_taps}, 64'h6ff);
		$display("test reset done");
		// rw bits store, unused bits read zero, an unmapped address ignores writes
		for (int i = 0; i < 6; i++) begin
			d = $urandom;
			wr(ra[i], d);
			rchk(ra[i], d & rm[i]);
		end
		wr(12'h507, 32'hffffffff);
		rchk(12'h507, 32'h0);
		wr(SEC_ADR_DCTL, 32'h0);
		$display("test access done");
		// control fields, routing and full bypass
		for (int i = 0; i < 5; i++) begin
			d = $urandom;
			d[14:8] = d[14:8] & d[6:0];
			d[17:16] = 2'(i);
			d[19:18] = 2'(i + 1);
			d[29:28] = (i == 4) ? 2'h3 : 2'(i % 3);
			wr(SEC_ADR_CTRL, d);
			chk({o_array_run, o_pre_run, o_pre_taps, o_array_taps}, {d[31:30], d[14:0]});
			chk(o_full_bypass, d[28] & d[29]);
			i_arr_ch0 = 24'($urandom);
			i_arr_ch1 = 24'($urandom);
			i_in_left = 24'($urandom);
			i_in_right = 24'($urandom);
			repeat (2) @(negedge i_clk);
			if (i == 4) chk({o_out1, o_out2}, {i_in_left, i_in_right});
			else chk({o_out1, o_out2}, {route(d[17:16]), route(d[19:18])});
			chk({o_eng_left, o_eng_right}, {i_in_left, i_in_right});
		end
		$display("test control done");
		// both stages stopped before any filter setting or coefficient is loaded
		wr(SEC_ADR_CTRL, 32'h0);
		chk({o_pre_run, o_array_run}, 2'h0);
		// every gain, ratio and post gain code in all three parameter sets
		for (int i = 0; i < 8; i++) begin
			c = 3'(i);
			d = {8'h0, 8'(i * 37), 1'b0, c, 1'b0, c, c, 5'(i * 3)};
			wr(SEC_ADR_COMP1, d);
			wr(SEC_ADR_COMP2, {1'b0, c + 3'h2, 1'b0, c + 3'h1, c + 3'h3, 5'(i), d[15:0]});
			chk(o_array_comp_select, d[23:16]);
			chk({o_comp_set[0].thr, o_comp_set[0].pre_shift}, {d[4:0], 4'(i + 1)});
			chk({o_comp_set[0].ratio_x3, o_comp_set[0].post_x4}, {6'(rx3[i]), 6'(px4[i])});
			chk(o_comp_set[1], {d[4:0], 4'(i + 1), 6'(rx3[i]), 6'(px4[i])});
			chk({o_comp_set[2].thr, o_comp_set[2].pre_shift}, {5'(i), 4'(3'(c + 3'h3)) + 4'h1});
			chk({o_comp_set[2].ratio_x3, o_comp_set[2].post_x4},
				{6'(rx3[3'(c + 3'h1)]), 6'(px4[3'(c + 3'h2)])});
		end
		$display("test compressor done");
		// coefficient writes refused with debug off, then debug mode and injection
		wr(SEC_ADR_DCTL, 32'h0);
		wr(12'h010, 32'h1234abcd);
		chk(o_coef_we, 1'b0);
		inj = $urandom;
		wr(SEC_ADR_DINJ, inj);
		d = {24'h0, 1'b1, 1'($urandom), 1'b0, 1'($urandom), 4'($urandom)};
		wr(SEC_ADR_DCTL, d);
		chk({o_debug_mode_on, o_step_on, o_acc_filter_pick, o_accumulator_index},
			{d[7:6], d[4:0]});
		@(negedge i_clk);
		chk({o_eng_left, o_eng_right}, {inj[23:0], inj[23:0]});
		d = $urandom;
		wr(12'h4ff, d);
		chk({o_coef_we, o_coef_addr, o_coef_wdata}, {1'b1, 11'h4ff, d});
		$display("test debug done");
		// live readback words, writes to read-only places ignored
		acc = {16'($urandom), 32'($urandom)};
		i_acc_value = acc;
		i_comp_out = 24'($urandom);
		i_debug_word = $urandom;
		wr(SEC_ADR_ACCL, 32'hffffffff);
		rchk(SEC_ADR_ACCL, acc[31:0]);
		rchk(SEC_ADR_ACCH, {16'h0, acc[47:32]});
		rchk(SEC_ADR_COUT, {8'h0, i_comp_out});
		rchk(SEC_ADR_DRB, i_debug_word);
		$display("test readback done");
		// statistics counters over mode codes 0000..0011 and 1000..1111, then clear hold
		for (int i = 0; i < 12; i++) begin
			ps = 4'($urandom_range(7));
			as = 4'($urandom_range(7));
			d = {4'h0, md[(i + 3) % 12], md[(i + 2) % 12], as, 4'h0, md[(i + 1) % 12], md[i], ps};
			wr(SEC_ADR_STAT, d | 32'h80008000);
			wr(SEC_ADR_STAT, d);
			cnt = '{0, 0, 0, 0};
			repeat (30) begin
				pe = 14'($urandom);
				ae = 14'($urandom);
				if ($urandom_range(1) == 1) pe.chan = ps[2:0];
				if ($urandom_range(1) == 1) ae.chan = as[2:0];
				i_pre_evt = pe;
				i_arr_evt = ae;
				cnt[0] += hit(d[7:4], ps, pe);
				cnt[1] += hit(d[11:8], ps, pe);
				cnt[2] += hit(d[23:20], as, ae);
				cnt[3] += hit(d[27:24], as, ae);
				@(negedge i_clk);
			end
			i_pre_evt = '0;
			i_arr_evt = '0;
			@(negedge i_clk);
			rchk(SEC_ADR_PC1, 32'(cnt[0]));
			rchk(SEC_ADR_PC2, 32'(cnt[1]));
			rchk(SEC_ADR_AC1, 32'(cnt[2]));
			rchk(SEC_ADR_AC2, 32'(cnt[3]));
			wr(SEC_ADR_STAT, d | 32'h80008000);
			i_pre_evt = '1;
			@(negedge i_clk);
			i_pre_evt = '0;
			rchk(SEC_ADR_PC1, 32'h0);
			rchk(SEC_ADR_AC2, 32'h0);
		end
		$display("test counters done");
		end_of_test();
	end
endmodule // testbench
